/* design/tsc_regs.vh */
// register map and field constants for the connection control block
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
`define TSC_OFR0       13'h0000
`define TSC_OFR1       13'h0004
`define TSC_FDR        13'h0008
`define TSC_MCR        13'h000C
`define TSC_CM_SEL     12
`define TSC_OFR_RST    16'h0000
`define TSC_RES_RST    4'h0
`define TSC_SYNC_RST   10'h002
`define TSC_FD_FLAG    11
`define TSC_FD_BUSY    15
`define TSC_MCR_START  3
`define TSC_MEAS_MAX   4'h9
`define TSC_CM_CHANNEL_LOOPBACK    15
`define TSC_CM_VC      14
`define TSC_CM_PC      13
`define TSC_CM_CCO     12
`define TSC_CM_OE      11
`define TSC_RESP_OK    2'h0
`define TSC_RESP_DEC   2'h3
`endif

/* design/tsc_connection_control.v */
// time slot interchange connection control with offset programming
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`include "tsc_regs.vh"
`default_nettype none
// Operation
// - After reset no stream is shifted and the measured delay reads flag set with low bits clear.
// - Each stream offset is programmable in half clock steps from zero to seven and a half periods.
// - The offset matching a measurement is its low three bits plus the inverted top flag as latch edge.
// - With a stream offset of zero or half a period, a set loopback bit makes the received channel data come from the same stream and channel transmitted.
// - Bit 14 chooses variable delay when low and constant one-frame delay when high.
// - With processor channel set, the low byte of the word is sent in place of switched data.
// - With processor channel clear, the word addresses the input stream and channel switched out.
// - Bit 12 leaves on the control channel pin one channel early, stream 0 first.
// - Bit 11 enables the serial output driver for the channel, zero leaves it released.
// - Bits 9 to 7 hold the source stream number.
// - Bits 6 to 0 hold the source channel number.
// - Offset settings exist for eight input streams numbered 0 to 7.
// - The offset sets how long after the frame pulse the receiver stores bit 0 of a frame.
module tsc_connection_control #(
  parameter STREAMS = 8,
  parameter CHANS   = 128
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        link_clk,
  input  wire        frame_pulse_n,
  input  wire [7:0]  rx_data,
  output reg  [7:0]  tx_data,
  output reg  [7:0]  tx_oe,
  output reg         control_channel_out
);
  localparam NW = STREAMS * CHANS;

  // pin synchronisers: {rx, frame, clock}
  reg  [9:0]  s1_q, s2_q, s3_q, f_q, p_q;
  wire [9:0]  f_d = (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
  wire        lk_edge = f_q[0] ^ p_q[0];
  wire        fs = ~f_q[1] & p_q[1];
  wire [7:0]  rxl = f_q[9:2];
  wire [7:0]  rx_chg = f_q[9:2] ^ p_q[9:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= `TSC_SYNC_RST;
      s2_q <= `TSC_SYNC_RST;
      s3_q <= `TSC_SYNC_RST;
      f_q  <= `TSC_SYNC_RST;
      p_q  <= `TSC_SYNC_RST;
    end else begin
      s1_q <= {rx_data, frame_pulse_n, link_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
      p_q  <= f_q;
    end
  end

  // half period counter since frame pulse, frame bank select
  reg  [11:0] hc_q;
  reg         bank_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      hc_q   <= 12'h000;
      bank_q <= 1'b0;
    end else if (fs) begin
      hc_q   <= 12'h000;
      bank_q <= ~bank_q;
    end else if (lk_edge && hc_q != 12'hFFF) begin
      hc_q <= hc_q + 12'h001;
    end
  end

  // memories and control registers
  reg  [15:0] cm_q [0:NW-1];
  reg  [7:0]  dm_q [0:2*NW-1];
  reg  [31:0] off_q;
  reg  [7:0]  rsh_q [0:STREAMS-1];

  // transmit side
  wire        tx_ev = lk_edge & ~hc_q[0] & ~hc_q[11];
  wire [9:0]  tq = hc_q[10:1];
  wire [7:0]  tx_d, oe_d;
  // receive side, one lane per stream
  wire [7:0]  rx_we, rx_bit;
  wire [63:0] rx_byte;
  wire [55:0] rx_ch;

  genvar g;
  generate
    for (g = 0; g < STREAMS; g = g + 1) begin : g_st
      localparam [2:0] sn = g;
      wire [15:0] w = cm_q[{sn, tq[9:3]}];
      // source stream and channel fields address the data memory
      wire [9:0]  src = {w[9:7], w[6:0]};
      // constant delay reads last frame's bank
      wire [7:0]  sw = dm_q[{bank_q ^ w[`TSC_CM_VC], src}];
      wire [7:0]  ob = w[`TSC_CM_PC] ? w[7:0] : sw;
      assign tx_d[g] = ob[~tq[2:0]];
      assign oe_d[g] = w[`TSC_CM_OE];
      // latch shift = 2*offset + latch edge, in half periods
      wire [3:0]  sh = off_q[4*g +: 4];
      wire [11:0] d = hc_q - {8'h00, sh};
      wire [9:0]  p = d[10:1];
      assign rx_we[g] = lk_edge & (hc_q >= {8'h00, sh}) & ~d[0] & ~d[11];
      wire        lb = cm_q[{sn, p[9:3]}][`TSC_CM_CHANNEL_LOOPBACK];
      assign rx_bit[g] = lb ? tx_d[g] : rxl[g];
      assign rx_byte[8*g +: 8] = {rsh_q[g][6:0], rx_bit[g]};
      assign rx_ch[7*g +: 7] = p[9:3];
    end
  endgenerate

  integer n;
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (n = 0; n < STREAMS; n = n + 1) begin
        rsh_q[n] <= 8'h00;
      end
    end else begin
      for (n = 0; n < STREAMS; n = n + 1) begin
        if (rx_we[n]) begin
          rsh_q[n] <= rx_byte[8*n +: 8];
          if (&rsh_ctr(hc_q, off_q[4*n +: 4])) begin
            dm_q[{bank_q, n[2:0], rx_ch[7*n +: 7]}] <= rx_byte[8*n +: 8];
          end
        end
      end
    end
  end

  // bit position within byte of the current receive sample
  function [2:0] rsh_ctr;
    input [11:0] h;
    input [3:0]  s;
    reg   [11:0] t;
    begin
      t = h - {8'h00, s};
      rsh_ctr = t[3:1];
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_data             <= 8'h00;
      tx_oe               <= 8'h00;
      control_channel_out <= 1'b0;
    end else if (tx_ev) begin
      tx_data             <= tx_d;
      tx_oe               <= oe_d;
      control_channel_out <= cm_q[{tq[2:0], tq[9:3] + 7'h01}][`TSC_CM_CCO];
    end
  end

  // delay measurement
  reg  [2:0]  ms_sel_q;
  reg         ms_arm_q, ms_run_q;
  reg  [3:0]  ms_cnt_q, ms_res_q;

  // axi write channel
  reg         aw_q, w_q;
  reg  [31:0] awa_q, wd_q;
  reg  [3:0]  ws_q;
  wire        wr_go = aw_q & w_q & ~s_axi_bvalid;
  wire [12:0] wa = awa_q[12:0];
  wire        wa_hi = |awa_q[31:13];
  wire        wa_cm = ~wa_hi & wa[`TSC_CM_SEL];
  wire [15:0] wm = {{8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [9:0]  wci = wa[11:2];
  wire        wa_o0 = ~wa_hi & (wa[12:2] == `TSC_OFR0 >> 2);
  wire        wa_o1 = ~wa_hi & (wa[12:2] == `TSC_OFR1 >> 2);
  wire        wa_fd = ~wa_hi & (wa[12:2] == `TSC_FDR >> 2);
  wire        wa_mc = ~wa_hi & (wa[12:2] == `TSC_MCR >> 2);

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready  = ~w_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awa_q        <= 32'h00000000;
      wd_q         <= 32'h00000000;
      ws_q         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TSC_RESP_OK;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wa_cm || wa_o0 || wa_o1 || wa_fd || wa_mc) begin
          s_axi_bresp <= `TSC_RESP_OK;
        end else begin
          s_axi_bresp <= `TSC_RESP_DEC;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      off_q <= {`TSC_OFR_RST, `TSC_OFR_RST};
      for (i = 0; i < NW; i = i + 1) begin
        cm_q[i] <= 16'h0000;
      end
    end else if (wr_go) begin
      if (wa_cm) begin
        cm_q[wci] <= (cm_q[wci] & ~wm) | (wd_q[15:0] & wm);
      end else if (wa_o0) begin
        off_q[15:0] <= (off_q[15:0] & ~wm) | (wd_q[15:0] & wm);
      end else if (wa_o1) begin
        off_q[31:16] <= (off_q[31:16] & ~wm) | (wd_q[15:0] & wm);
      end
    end
  end

  // measurement counts half periods from frame pulse to first data change
  wire mc_go = wr_go & wa_mc & ws_q[0];
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_sel_q <= 3'h0;
      ms_arm_q <= 1'b0;
      ms_run_q <= 1'b0;
      ms_cnt_q <= 4'h0;
      ms_res_q <= `TSC_RES_RST;
    end else begin
      if (mc_go) begin
        ms_sel_q <= wd_q[2:0];
        ms_arm_q <= wd_q[`TSC_MCR_START];
      end else if (fs && ms_arm_q) begin
        ms_arm_q <= 1'b0;
      end
      if (fs && ms_arm_q) begin
        ms_run_q <= 1'b1;
        ms_cnt_q <= 4'h0;
      end else if (ms_run_q) begin
        if (rx_chg[ms_sel_q] || (lk_edge && ms_cnt_q == `TSC_MEAS_MAX)) begin
          ms_run_q <= 1'b0;
          ms_res_q <= ms_cnt_q;
        end else if (lk_edge) begin
          ms_cnt_q <= ms_cnt_q + 4'h1;
        end
      end
    end
  end

  // read decode
  wire [12:0] ra = s_axi_araddr[12:0];
  wire        ra_hi = |s_axi_araddr[31:13];
  reg  [31:0] rd_d;
  reg  [1:0]  rr_d;
  always @* begin
    rd_d = 32'h00000000;
    rr_d = `TSC_RESP_OK;
    if (ra_hi) begin
      rr_d = `TSC_RESP_DEC;
    end else if (ra[`TSC_CM_SEL]) begin
      rd_d[15:0] = cm_q[ra[11:2]];
    end else if (ra[12:2] == `TSC_OFR0 >> 2) begin
      rd_d[15:0] = off_q[15:0];
    end else if (ra[12:2] == `TSC_OFR1 >> 2) begin
      rd_d[15:0] = off_q[31:16];
    end else if (ra[12:2] == `TSC_FDR >> 2) begin
      rd_d[`TSC_FD_BUSY] = ms_arm_q | ms_run_q;
      rd_d[`TSC_FD_FLAG] = ~ms_res_q[0];
      rd_d[2:0]          = ms_res_q[3:1];
    end else if (ra[12:2] == `TSC_MCR >> 2) begin
      rd_d[2:0] = ms_sel_q;
    end else begin
      rr_d = `TSC_RESP_DEC;
    end
  end

  // two-entry read response buffer
  reg  [33:0] rb_q [0:1];
  reg  [1:0]  rc_q;
  reg         rw_q, rp_q;
  wire        push = s_axi_arvalid & s_axi_arready;
  wire        pop = s_axi_rvalid & s_axi_rready;
  assign s_axi_arready = (rc_q != 2'h2);
  assign s_axi_rvalid  = (rc_q != 2'h0);
  assign s_axi_rdata   = rb_q[rp_q][31:0];
  assign s_axi_rresp   = rb_q[rp_q][33:32];

  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_q     <= 2'h0;
      rw_q     <= 1'b0;
      rp_q     <= 1'b0;
      rb_q[0]  <= 34'h000000000;
      rb_q[1]  <= 34'h000000000;
    end else begin
      if (push) begin
        rb_q[rw_q] <= {rr_d, rd_d};
        rw_q       <= ~rw_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        rc_q <= rc_q + 2'h1;
      end else if (pop && !push) begin
        rc_q <= rc_q - 2'h1;
      end
    end
  end
endmodule // tsc_connection_control
`default_nettype wire

/* tb/tsc_monitor.sv */
// assertion checker for the connection control block
`default_nettype none
module tsc_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [7:0]  tx_data,
  input wire logic [7:0]  tx_oe,
  input wire logic        control_channel_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst;
    $rose(aresetn) |-> tx_oe == 8'h00 && !control_channel_out && s_axi_awready && !s_axi_bvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_bans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_busy: assert property (p_busy) else $error("address taken while held");
  property p_rans;
    s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_decz;
    s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0;
  endproperty
  a_decz: assert property (p_decz) else $error("refused read carries data");
  property p_txhold;
    !$stable(tx_data) |=> $stable(tx_data)[*3];
  endproperty
  a_txhold: assert property (p_txhold) else $error("serial data changed too soon");
  property p_oehold;
    !$stable(tx_oe) |=> $stable(tx_oe)[*3];
  endproperty
  a_oehold: assert property (p_oehold) else $error("driver enable changed too soon");
  property p_ccohold;
    !$stable(control_channel_out) |=> $stable(control_channel_out)[*3];
  endproperty
  a_ccohold: assert property (p_ccohold) else $error("control bit changed too soon");
endmodule // tsc_monitor
`default_nettype wire

/* tb/tsc_stream_peer.sv */
// serial stream peer: link clock, frame pulse, receive lines, capture of channel 0
`default_nettype none
module tsc_stream_peer (
  output logic       link_clk,
  output logic       frame_pulse_n,
  output logic [7:0] rx_data,
  input  wire logic [7:0] tx_data,
  input  wire logic [7:0] tx_oe,
  output logic [7:0] tx_byte,
  output logic [7:0] oe_byte,
  input  wire logic  control_channel_out,
  output logic [7:0] cco_byte,
  output int         frames
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    frame_pulse_n = 1'b1;
    rx_data = 8'h04; // stream 2 all ones, others all zeros
    tx_byte = 8'h00;
    oe_byte = 8'h00;
    cco_byte = 8'h00;
    frames = 0;
  end
  // link edges kept off the system clock edges
  initial begin
    #1;
    forever #62.5 link_clk = ~link_clk;
  end
  // frame pulse between link edges, bits sampled mid cell, msb first
  initial begin
    #93.5;
    forever begin
      frame_pulse_n = 1'b0;
      #110;
      for (int k = 0; k < 8; k++) begin
        tx_byte = {tx_byte[6:0], tx_data[0]};
        oe_byte = {oe_byte[6:0], tx_oe[0]};
        cco_byte = {cco_byte[6:0], control_channel_out};
        if (k == 0) #15 frame_pulse_n = 1'b1;
        #(k == 0 ? 110 : 125);
      end
      frames++;
      #126890;
    end
  end
endmodule // tsc_stream_peer
`default_nettype wire

/* tb/tsc_connection_control_bench.sv */
// self-checking bench for the connection control block
`default_nettype none
module tsc_connection_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'h3;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_wready, s_axi_arready;
  logic        link_clk, frame_pulse_n, control_channel_out;
  logic [7:0]  rx_data, tx_data, tx_oe, tx_byte, oe_byte, cco_byte;
  int          frames, n_errors = 0, comparisons = 0;
  tsc_connection_control DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .frame_pulse_n,
    .rx_data, .tx_data, .tx_oe, .control_channel_out);
  tsc_stream_peer peer (.link_clk, .frame_pulse_n, .rx_data, .tx_data, .tx_oe, .tx_byte,
    .oe_byte, .control_channel_out, .cco_byte, .frames);
  always #5 aclk = ~aclk;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (t >= 60) begin
      n_errors++;
      end_sim();
    end else begin
      chk("bresp", s_axi_bresp, er);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (t >= 60) begin
      n_errors++;
      end_sim();
    end else begin
      chk("read", {s_axi_rresp, s_axi_rdata}, {er, ed});
    end
  endtask
  task automatic waitf(input int n);
    int f, t;
    f = frames;
    for (t = 0; t < 13000 * n && frames < f + n; t++) @(posedge aclk);
    if (frames < f + n) begin
      n_errors++;
      end_sim();
    end
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(32'h8, 32'h800, 2'h0);
    rd(32'h0, 32'h0, 2'h0);
    waitf(1);
    chk("oe_byte", oe_byte, 8'h00);
    $display("reset test done");
    wr(32'h0, 32'h9, 2'h0);
    wr(32'h4, 32'h9000, 2'h0);
    rd(32'h0, 32'h9, 2'h0);
    rd(32'h4, 32'h9000, 2'h0);
    rd(32'h10, 32'h0, 2'h3);
    wr(32'h10, 32'h1, 2'h3);
    $display("register test done");
    wr(32'h1000, 32'h28A5, 2'h0);
    wr(32'h1004, 32'h1000, 2'h0);
    rd(32'h1000, 32'h28A5, 2'h0);
    waitf(2);
    chk("tx_byte", tx_byte, 8'hA5);
    chk("oe_byte", oe_byte, 8'hFF);
    chk("cco_byte", cco_byte, 8'h80);
    $display("processor channel test done");
    wr(32'h1000, 32'h4905, 2'h0);
    waitf(2);
    chk("tx_byte", tx_byte, 8'hFF);
    $display("switched channel test done");
    wr(32'h0, 32'h0, 2'h0);
    wr(32'hC, 32'hA, 2'h0);
    wr(32'h1200, 32'hA83C, 2'h0);
    wr(32'h1000, 32'h0880, 2'h0);
    waitf(3);
    chk("tx_byte", tx_byte, 8'h3C);
    rd(32'h8, 32'h4, 2'h0);
    $display("loopback test done");
    end_sim();
  end
endmodule // tsc_connection_control_bench
bind tsc_connection_control tsc_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .tx_data, .tx_oe, .control_channel_out);
`default_nettype wire
